//--- fos_dec_model.sv
`timescale 1ns/1ps
`default_nettype none

// Decode stage stand-in: presents one operand request per clock cycle
module fos_dec_model (
    input wire logic clock,
    output var logic req_valid,
    output var logic use_constant,
    output var logic [7:0] imm_byte,
    output var fos_pkg::fos_const_e const_kind,
    output var logic [4:0] const_shift,
    output var logic [31:0] shift_source_register,
    output var fos_pkg::fos_shift_e shift_kind,
    output var logic [7:0] shift_amount,
    output var logic flag_setting,
    output var logic carry_in
);
    // Defined levels from time zero so nothing unknown reaches the stage
    initial begin
        req_valid = 1'b0;
        use_constant = 1'b0;
        imm_byte = 8'h00;
        const_kind = fos_pkg::FOS_CONST_SHIFTED;
        const_shift = 5'h00;
        shift_source_register = 32'h0000_0000;
        shift_kind = fos_pkg::FOS_SH_NONE;
        shift_amount = 8'h00;
        flag_setting = 1'b0;
        carry_in = 1'b0;
    end

    // Change one step after the edge, so the stage never races the driver
    task automatic issue(input logic v, input logic uc, input logic [7:0] b,
        input fos_pkg::fos_const_e ck, input logic [4:0] cs,
        input logic [31:0] s, input fos_pkg::fos_shift_e sk,
        input logic [7:0] n, input logic fs, input logic ci);
        @(posedge clock);
        #1;
        req_valid = v;
        use_constant = uc;
        imm_byte = b;
        const_kind = ck;
        const_shift = cs;
        shift_source_register = s;
        shift_kind = sk;
        shift_amount = n;
        flag_setting = fs;
        carry_in = ci;
    endtask : issue
endmodule : fos_dec_model

`default_nettype wire

//--- fos_map.svh
`ifndef FOS_MAP_SVH
`define FOS_MAP_SVH

// Operand and shift geometry
`define FOS_WORD_W 32
`define FOS_IMM_W 8
`define FOS_AMT_W 8
`define FOS_POS_W 5
`define FOS_SMALL_MAX 32'h0000_00ff
`define FOS_SIGN_BIT 31
`define FOS_WORD_LEN 8'h20
`define FOS_LEFT_MAX 8'h1f
// Delay from request to answer, in clock cycles
`define FOS_LATENCY 1

`endif

//--- fos_operand.sv
`timescale 1ns/1ps
`default_nettype none
`include "fos_map.svh"

module fos_operand #(
    parameter int WORD_W = `FOS_WORD_W,
    parameter int AMT_W = `FOS_AMT_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic use_constant,
    input wire logic [`FOS_IMM_W-1:0] imm_byte,
    input wire fos_pkg::fos_const_e const_kind,
    input wire logic [`FOS_POS_W-1:0] const_shift,
    input wire logic [WORD_W-1:0] shift_source_register,
    input wire fos_pkg::fos_shift_e shift_kind,
    input wire logic [AMT_W-1:0] shift_amount,
    input wire logic flag_setting,
    input wire logic carry_in,
    output logic out_valid,
    output logic [WORD_W-1:0] flexible_second_operand,
    output logic carry_out,
    output logic carry_written
);

    initial begin
        if (WORD_W != 32) begin
            $error("fos_operand: only a 32-bit word is served");
        end
        // The shifter reads all eight length bits, so no other width fits
        if (AMT_W != 8) begin
            $error("fos_operand: shift amount must be 8 bits wide");
        end
    end

    // Logical shift right; lengths of a word or more give zero
    function automatic logic [32:0] lsr_c(input logic [31:0] v,
                                          input logic [7:0] n);
        logic [63:0] wide;
        wide = {v, 32'h0000_0000} >> n;
        // Carry is the last bit shifted out, bit n-1
        if (n > `FOS_WORD_LEN) begin
            lsr_c = {1'b0, 32'h0000_0000};
        end else begin
            lsr_c = {wide[31], wide[63:32]};
        end
    endfunction : lsr_c

    // Rotate right by 0..31; carry is the new bit 31
    function automatic logic [32:0] ror_c(input logic [31:0] v,
                                          input logic [4:0] n);
        logic [63:0] wide;
        wide = {v, v} >> n;
        ror_c = {wide[31], wide[31:0]};
    endfunction : ror_c

    // Constant expander
    logic [WORD_W-1:0] const_value;
    logic const_carry_hit;
    always_comb begin
        const_value = '0;
        const_carry_hit = 1'b0;
        unique case (const_kind)
            fos_pkg::FOS_CONST_SHIFTED: begin
                const_value = {24'h00_0000, imm_byte} << const_shift;
                // Only shifted constants above 255 touch the carry
                const_carry_hit = const_value > `FOS_SMALL_MAX;
            end
            fos_pkg::FOS_CONST_REP_02: begin
                const_value = {8'h00, imm_byte, 8'h00, imm_byte};
            end
            fos_pkg::FOS_CONST_REP_13: begin
                const_value = {imm_byte, 8'h00, imm_byte, 8'h00};
            end
            fos_pkg::FOS_CONST_REP_ALL: begin
                const_value = {4{imm_byte}};
            end
            default: begin
                const_value = '0; // Illegal code yields zero, no carry
            end
        endcase
    end

    // Register shifter on a copy of the source; the source is input-only
    logic [WORD_W-1:0] src_copy;
    logic [WORD_W-1:0] sh_value;
    logic sh_carry;
    logic sh_hit;
    logic [32:0] tmp;
    logic [7:0] amt;
    assign src_copy = shift_source_register;
    always_comb begin
        amt = shift_amount[7:0];
        sh_value = src_copy;
        sh_carry = carry_in;
        sh_hit = 1'b0;
        tmp = '0;
        unique case (shift_kind)
            fos_pkg::FOS_SH_NONE: begin
                sh_value = src_copy;
            end
            fos_pkg::FOS_SH_ASR: begin
                if (amt != 8'h00) begin
                    sh_hit = 1'b1;
                    if (amt >= `FOS_WORD_LEN) begin
                        // Saturate to sign fill
                        sh_value = {32{src_copy[`FOS_SIGN_BIT]}};
                        sh_carry = src_copy[`FOS_SIGN_BIT];
                    end else begin
                        sh_value = 32'($signed(src_copy) >>> amt);
                        sh_carry = src_copy[amt[4:0] - 5'd1];
                    end
                end
            end
            fos_pkg::FOS_SH_LSL: begin
                if (amt != 8'h00) begin
                    sh_hit = 1'b1;
                    if (amt > `FOS_WORD_LEN) begin
                        sh_value = '0;
                        sh_carry = 1'b0;
                    end else begin
                        tmp = {1'b0, src_copy} << amt;
                        sh_value = tmp[31:0];
                        sh_carry = tmp[32]; // Bit 32-n of source
                    end
                end
            end
            fos_pkg::FOS_SH_LSR: begin
                if (amt != 8'h00) begin
                    sh_hit = 1'b1;
                    tmp = lsr_c(src_copy, amt);
                    sh_value = tmp[31:0];
                    sh_carry = tmp[32];
                end
            end
            fos_pkg::FOS_SH_ROR: begin
                if (amt != 8'h00) begin
                    sh_hit = 1'b1;
                    // Reduce modulo the word; 32 returns source, carry bit 31
                    tmp = ror_c(src_copy, amt[4:0]);
                    sh_value = tmp[31:0];
                    sh_carry = tmp[32];
                end
            end
            fos_pkg::FOS_SH_RRX: begin
                sh_hit = 1'b1;
                sh_value = {carry_in, src_copy[31:1]};
                sh_carry = src_copy[0];
            end
            default: begin
                sh_value = src_copy;
            end
        endcase
    end

    // Choose operand and carry; flag_setting gates every carry update
    logic [WORD_W-1:0] next_operand;
    logic next_carry;
    logic next_written;
    always_comb begin
        if (use_constant) begin
            next_operand = const_value;
            next_written = flag_setting && const_carry_hit;
            next_carry = next_written ? const_value[`FOS_SIGN_BIT] : carry_in;
        end else begin
            next_operand = sh_value;
            next_written = flag_setting && sh_hit;
            next_carry = next_written ? sh_carry : carry_in;
        end
    end

    // Output stage register: one cycle from request to answer
    logic [WORD_W+1:0] stage_q;
    fos_stage_reg #(
        .WIDTH(WORD_W + 2)
    ) u_stage (
        .clock(clock),
        .rst_n(rst_n),
        .d({next_written, next_carry, next_operand}),
        .q(stage_q)
    );
    assign flexible_second_operand = stage_q[WORD_W-1:0];
    assign carry_out = stage_q[WORD_W];
    assign carry_written = stage_q[WORD_W+1];

    // Valid follows the request by one cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= req_valid;
        end
    end

    // Zero-length register shift other than RRX must leave carry alone
    a_zero_len_carry: assert property (@(posedge clock) disable iff (!rst_n)
        (!use_constant && shift_kind != fos_pkg::FOS_SH_RRX
         && shift_amount == '0)
        |=> (!carry_written && carry_out == $past(carry_in)))
        else $error("zero-length shift changed carry");
    a_pass_through: assert property (@(posedge clock) disable iff (!rst_n)
        (!use_constant && shift_kind == fos_pkg::FOS_SH_NONE)
        |=> flexible_second_operand == $past(shift_source_register))
        else $error("unshifted operand altered");
    a_no_flag_carry: assert property (@(posedge clock) disable iff (!rst_n)
        !flag_setting |=> (!carry_written && carry_out == $past(carry_in)))
        else $error("carry written without flag setting");
    a_rrx_shape: assert property (@(posedge clock) disable iff (!rst_n)
        (!use_constant && shift_kind == fos_pkg::FOS_SH_RRX && flag_setting)
        |=> (flexible_second_operand[31] == $past(carry_in)
             && carry_out == $past(shift_source_register[0])))
        else $error("extend rotate wrong");
    a_asr_big: assert property (@(posedge clock) disable iff (!rst_n)
        (!use_constant && shift_kind == fos_pkg::FOS_SH_ASR
         && shift_amount >= 8'h20)
        |=> flexible_second_operand == {32{$past(shift_source_register[31])}})
        else $error("large arithmetic shift wrong");
    a_lsl_big: assert property (@(posedge clock) disable iff (!rst_n)
        (!use_constant && flag_setting && shift_amount > 8'h20
         && (shift_kind == fos_pkg::FOS_SH_LSL
             || shift_kind == fos_pkg::FOS_SH_LSR))
        |=> (flexible_second_operand == '0 && carry_written && !carry_out))
        else $error("long logical shift not zero");
    a_small_const: assert property (@(posedge clock) disable iff (!rst_n)
        (use_constant && (const_kind != fos_pkg::FOS_CONST_SHIFTED
         || const_value <= 32'h0000_00ff))
        |=> (!carry_written && carry_out == $past(carry_in)))
        else $error("small constant touched carry");
    a_big_const: assert property (@(posedge clock) disable iff (!rst_n)
        (use_constant && flag_setting && const_kind == fos_pkg::FOS_CONST_SHIFTED
         && const_value > 32'h0000_00ff)
        |=> (carry_written && carry_out == flexible_second_operand[31]))
        else $error("shifted constant carry wrong");
    a_ror_32: assert property (@(posedge clock) disable iff (!rst_n)
        (!use_constant && shift_kind == fos_pkg::FOS_SH_ROR
         && shift_amount == 8'h20)
        |=> flexible_second_operand == $past(shift_source_register))
        else $error("rotate by word changed value");

endmodule : fos_operand
`default_nettype wire

//--- fos_pkg.sv
package fos_pkg;

    // Shape of the constant expander output
    typedef enum logic [2:0] {
        FOS_CONST_SHIFTED,
        FOS_CONST_REP_02,
        FOS_CONST_REP_13,
        FOS_CONST_REP_ALL
    } fos_const_e;

    // Register shifter operations
    typedef enum logic [2:0] {
        FOS_SH_NONE,
        FOS_SH_ASR,
        FOS_SH_LSL,
        FOS_SH_LSR,
        FOS_SH_ROR,
        FOS_SH_RRX
    } fos_shift_e;

endpackage : fos_pkg

//--- fos_stage_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "fos_map.svh"

// Output register of the operand stage; holds operand, carry_out and carry_written on a flop (out_valid has its own)
module fos_stage_reg #(
    parameter int WIDTH = 34
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    initial begin
        if (WIDTH < 1) begin
            $error("fos_stage_reg: WIDTH must be positive");
        end
    end

    // Plain capture register, cleared at reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : fos_stage_reg
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid, use_constant, flag_setting, carry_in;
    logic out_valid, carry_out, carry_written;
    logic [7:0] imm_byte, shift_amount;
    logic [4:0] const_shift;
    logic [31:0] src, operand;
    fos_pkg::fos_const_e const_kind;
    fos_pkg::fos_shift_e shift_kind;
    int mismatches = 0;
    int checked = 0;
    logic pend = 1'b0;
    logic [34:0] expd;
    // Lengths chosen to hit every boundary of the shift rules
    logic [7:0] lens [10] = '{8'h00, 8'h01, 8'h02, 8'h0f, 8'h1f, 8'h20,
        8'h21, 8'h40, 8'h41, 8'hff};

    always #25 clock = ~clock;

    fos_dec_model u_dec (.clock(clock), .req_valid(req_valid),
        .use_constant(use_constant), .imm_byte(imm_byte),
        .const_kind(const_kind), .const_shift(const_shift),
        .shift_source_register(src), .shift_kind(shift_kind),
        .shift_amount(shift_amount), .flag_setting(flag_setting),
        .carry_in(carry_in));

    fos_operand u_dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
        .use_constant(use_constant), .imm_byte(imm_byte),
        .const_kind(const_kind), .const_shift(const_shift),
        .shift_source_register(src), .shift_kind(shift_kind),
        .shift_amount(shift_amount), .flag_setting(flag_setting),
        .carry_in(carry_in), .out_valid(out_valid),
        .flexible_second_operand(operand), .carry_out(carry_out),
        .carry_written(carry_written));

    // Reference result packed as {written, carry, operand}
    function automatic logic [33:0] ref_op(input logic uc,
        input logic [7:0] b, input fos_pkg::fos_const_e ck,
        input logic [4:0] cs, input logic [31:0] s,
        input fos_pkg::fos_shift_e sk, input logic [7:0] n,
        input logic fs, input logic ci);
        logic [31:0] r;
        logic c;
        logic w;
        int m;
        r = s;
        c = ci;
        w = 1'b0;
        m = n % 32;
        if (uc) begin
            case (ck)
                fos_pkg::FOS_CONST_SHIFTED: begin
                    r = 32'(b) << cs;
                    w = r > 32'h0000_00ff;
                    c = r[31];
                end
                fos_pkg::FOS_CONST_REP_02: r = {8'h00, b, 8'h00, b};
                fos_pkg::FOS_CONST_REP_13: r = {b, 8'h00, b, 8'h00};
                default: r = {b, b, b, b};
            endcase
        end else if (sk == fos_pkg::FOS_SH_RRX) begin
            r = {ci, s[31:1]};
            c = s[0];
            w = 1'b1;
        end else if (n != 8'h00 && sk != fos_pkg::FOS_SH_NONE) begin
            w = 1'b1;
            case (sk)
                fos_pkg::FOS_SH_ASR: begin
                    r = n >= 32 ? {32{s[31]}} : 32'($signed(s) >>> n);
                    c = n >= 32 ? s[31] : s[n-1];
                end
                fos_pkg::FOS_SH_LSL: begin
                    r = n >= 32 ? 32'h0000_0000 : s << n;
                    c = n > 32 ? 1'b0 : (n == 32 ? s[0] : s[32-n]);
                end
                fos_pkg::FOS_SH_LSR: begin
                    r = n >= 32 ? 32'h0000_0000 : s >> n;
                    c = n > 32 ? 1'b0 : s[n-1];
                end
                default: begin
                    r = m == 0 ? s : (s >> m) | (s << (32 - m));
                    c = s[(m + 31) % 32];
                end
            endcase
        end
        w = w & fs;
        return {w, w ? c : ci, r};
    endfunction : ref_op

    task automatic chk(input logic [34:0] got, input logic [34:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One request per cycle; the previous answer is judged as this one goes
    task automatic op(input logic v, input logic uc, input logic [7:0] b,
        input fos_pkg::fos_const_e ck, input logic [4:0] cs,
        input logic [31:0] s, input fos_pkg::fos_shift_e sk,
        input logic [7:0] n, input logic fs, input logic ci);
        u_dec.issue(v, uc, b, ck, cs, s, sk, n, fs, ci);
        if (pend) chk({out_valid, carry_written, carry_out, operand}, expd);
        expd = {v, ref_op(uc, b, ck, cs, s, sk, n, fs, ci)};
        pend = 1'b1;
    endtask : op

    task automatic cop(input logic [7:0] b, input fos_pkg::fos_const_e ck,
        input logic [4:0] cs, input logic fs, input logic ci);
        op(1'b1, 1'b1, b, ck, cs, 32'h5555_aaaa, fos_pkg::FOS_SH_LSL,
            8'h03, fs, ci);
    endtask : cop

    task automatic sop(input logic [31:0] s, input fos_pkg::fos_shift_e sk,
        input logic [7:0] n, input logic fs, input logic ci);
        op(1'b1, 1'b0, 8'h3c, fos_pkg::FOS_CONST_SHIFTED, 5'h07, s, sk, n,
            fs, ci);
    endtask : sop

    // Idle slot: out_valid must drop while inputs are still captured
    task automatic idle(input string name);
        op(1'b0, 1'b0, 8'h00, fos_pkg::FOS_CONST_SHIFTED, 5'h00,
            32'hffff_0000, fos_pkg::FOS_SH_LSR, 8'h02, 1'b1, 1'b1);
        $display("%s finished", name);
    endtask : idle

    task automatic sweep(input fos_pkg::fos_shift_e sk);
        for (int i = 0; i < 10; i++) begin
            sop(32'h8000_0002, sk, lens[i], 1'b1, i[0]);
            sop(32'h4c3a_5a3d, sk, lens[i], 1'b1, ~i[0]);
        end
    endtask : sweep

    task automatic test_const;
        for (int i = 0; i < 32; i++) begin
            cop(8'ha5, fos_pkg::FOS_CONST_SHIFTED, 5'(i), 1'b1, i[0]);
        end
        cop(8'h81, fos_pkg::FOS_CONST_SHIFTED, 5'h18, 1'b0, 1'b0);
        cop(8'hc3, fos_pkg::FOS_CONST_REP_02, 5'h04, 1'b1, 1'b0);
        cop(8'h5a, fos_pkg::FOS_CONST_REP_13, 5'h1f, 1'b1, 1'b1);
        cop(8'hf7, fos_pkg::FOS_CONST_REP_ALL, 5'h08, 1'b1, 1'b0);
        idle("test_const");
    endtask : test_const

    task automatic test_arith;
        sweep(fos_pkg::FOS_SH_ASR);
        idle("test_arith");
    endtask : test_arith

    task automatic test_logical;
        sweep(fos_pkg::FOS_SH_LSL);
        sweep(fos_pkg::FOS_SH_LSR);
        idle("test_logical");
    endtask : test_logical

    task automatic test_rotate;
        sweep(fos_pkg::FOS_SH_ROR);
        sop(32'h8000_0003, fos_pkg::FOS_SH_RRX, 8'h00, 1'b1, 1'b0);
        sop(32'h0000_0002, fos_pkg::FOS_SH_RRX, 8'h05, 1'b1, 1'b1);
        sop(32'h0000_0001, fos_pkg::FOS_SH_RRX, 8'h01, 1'b0, 1'b0);
        idle("test_rotate");
    endtask : test_rotate

    task automatic test_plain;
        sop(32'h1234_5678, fos_pkg::FOS_SH_NONE, 8'h00, 1'b1, 1'b1);
        sop(32'h9234_5679, fos_pkg::FOS_SH_NONE, 8'h04, 1'b1, 1'b0);
        sop(32'h9234_5679, fos_pkg::FOS_SH_LSL, 8'h00, 1'b1, 1'b0);
        sop(32'h0000_0008, fos_pkg::FOS_SH_LSR, 8'h04, 1'b0, 1'b0);
        sop(32'h0000_0008, fos_pkg::FOS_SH_LSR, 8'h04, 1'b1, 1'b0);
        idle("test_plain");
    endtask : test_plain

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // Outputs must be clear while reset is held, then the tests run
    initial begin
        repeat (4) @(posedge clock);
        #1;
        chk({out_valid, carry_written, carry_out, operand}, 35'h0_0000_0000);
        @(posedge clock);
        #1;
        rst_n = 1'b1;
        test_const();
        test_arith();
        test_logical();
        test_rotate();
        test_plain();
        idle("flush");
        // The flush slot's own answer is judged here before the verdict
        @(posedge clock);
        #1;
        chk({out_valid, carry_written, carry_out, operand}, expd);
        end_sim();
    end

    // About 140 cycles are needed; a hang is cut off well after that
    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        end_sim();
    end
endmodule : testbench

`default_nettype wire
